/* hdl/ppob_top.sv */
// ***************************************************************
// Pulse-width / pulse-position output block, eight channels
// ***************************************************************
// File holds the top module with its Wishbone slave and channels.
// Assumes classic Wishbone master on clock_in and synchronous inputs.
`timescale 1ns/1ns
module ppob_top (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [3:0] wb_sel_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  input wire logic global_sync_in,
  input wire logic [ppob_pkg::EXT_SYNC_NUM-1:0] ext_sync_in,
  output logic [ppob_pkg::EXT_SYNC_NUM-1:0] ext_sync_claim_out,
  output logic [ppob_pkg::CH_NUM-1:0] pulse_output_pins_out
);
  import ppob_pkg::*;

  // ***************************************************************
  // Declarations
  // ***************************************************************
  logic [CTRL_W-1:0] ctrl_reg;              // Block control
  logic [CNT_W-1:0] period_reg;             // Period in counts
  logic [CNT_W-1:0] prescale_reg;           // Prescale divide minus one
  logic [CNT_W-1:0] match_reg [MATCH_NUM];  // Shared edge compares
  logic [CH_W-1:0] chan_reg [CH_NUM];       // Per-channel setup
  logic [CH_NUM-1:0] pin_reg;               // Output pins
  logic [CH_NUM-1:0] ppm_reg;               // Pulse-position state
  logic [CH_NUM-1:0] tog_reg;               // Counter-mode toggle
  logic [7:0] use_bits [CH_NUM];            // Match use per channel
  logic [CNT_W-1:0] lead_v [CH_NUM];        // Selected lead compare
  logic [CNT_W-1:0] trail_v [CH_NUM];       // Selected trail compare
  logic [CNT_W-1:0] lead_p1 [CH_NUM];       // Lead plus one count
  logic [CH_NUM-1:0] active;                // Level before inversion
  logic [MATCH_NUM-1:0] hit;                // Counter equals match
  logic [CNT_W-1:0] cnt;                    // Period counter
  logic step;                               // Counter just moved
  logic sync_pulse;                         // Accepted sync edge
  logic wb_req;                             // New bus request
  logic wb_wr;                              // Write taken this cycle
  logic [31:0] rd_next;                     // Read data to register
  logic is_match;
  logic is_chan;
  logic is_use;
  logic [2:0] sub_idx;

  // Merge write data by byte enables
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        res[8*b +: 8] = new_v[8*b +: 8];
      end
    end
    return res;
  endfunction

  // ***************************************************************
  // Wishbone decode
  // ***************************************************************
  // One request per ack; a held request is not taken twice
  assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
  assign wb_wr = wb_req && wb_we_in;
  assign sub_idx = wb_adr_in[4:2];
  assign is_match = wb_adr_in[7:4] == {3'h0, PAGE_MATCH[0]};
  assign is_chan = wb_adr_in[7:5] == PAGE_CHAN;
  assign is_use = wb_adr_in[7:5] == PAGE_USE;

  // Ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      wb_ack_out <= 1'b0;
    end else begin
      wb_ack_out <= wb_req;
    end
  end

  // Block control, period and prescale, one set per block
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      ctrl_reg <= CTRL_RST;
      period_reg <= PERIOD_RST;
      prescale_reg <= PRESCALE_RST;
    end else if (wb_wr) begin
      case (wb_adr_in)
        ADDR_CTRL: ctrl_reg <= CTRL_W'(lane_merge(32'(ctrl_reg), wb_dat_in, wb_sel_in));
        ADDR_PERIOD: period_reg <=
          CNT_W'(lane_merge(32'(period_reg), wb_dat_in, wb_sel_in));
        ADDR_PRESCALE: prescale_reg <=
          CNT_W'(lane_merge(32'(prescale_reg), wb_dat_in, wb_sel_in));
        default: ;  // Other offsets handled below or ignored
      endcase
    end
  end

  // Match registers; a duty write here moves every bound channel
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int m = 0; m < MATCH_NUM; m++) begin
        match_reg[m] <= MATCH_RST;
      end
    end else if (wb_wr && is_match) begin
      match_reg[sub_idx[1:0]] <=
        CNT_W'(lane_merge(32'(match_reg[sub_idx[1:0]]), wb_dat_in, wb_sel_in));
    end
  end

  // Channel setup addressed by channel number
  // Timing fields survive a disable so enable resumes them
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      for (int c = 0; c < CH_NUM; c++) begin
        chan_reg[c] <= CH_RST;
      end
    end else if (wb_wr && is_chan) begin
      chan_reg[sub_idx] <= CH_W'(lane_merge(32'(chan_reg[sub_idx]), wb_dat_in, wb_sel_in));
    end
  end

  // Read mux; unmapped offsets read zero and still ack
  always_comb begin
    rd_next = 32'h0000_0000;
    if (is_match) begin
      rd_next = 32'(match_reg[sub_idx[1:0]]);
    end else if (is_chan) begin
      rd_next = 32'(chan_reg[sub_idx]);
    end else if (is_use) begin
      rd_next = 32'(use_bits[sub_idx]);
    end else begin
      case (wb_adr_in)
        ADDR_CTRL: rd_next = 32'(ctrl_reg);
        ADDR_PERIOD: rd_next = 32'(period_reg);
        ADDR_PRESCALE: rd_next = 32'(prescale_reg);
        ADDR_STATUS: rd_next = {20'h00000, hit, pin_reg};
        default: rd_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      wb_dat_out <= 32'h0000_0000;
    end else if (wb_req && !wb_we_in) begin
      wb_dat_out <= rd_next;
    end
  end

  // ***************************************************************
  // Sync and period counter
  // ***************************************************************
  ppob_sync_detect #(.EXT_NUM(EXT_SYNC_NUM)) u_sync (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .global_sync_in(global_sync_in),
    .ext_sync_in(ext_sync_in),
    .src_in(ctrl_reg[CTRL_SRC_LSB +: SRC_W]),
    .edge_in(ppob_edge_e'(ctrl_reg[CTRL_EDGE_LSB +: 2])),
    .sync_out(sync_pulse),
    .claim_out(ext_sync_claim_out)
  );

  ppob_timebase #(.CNT_W(CNT_W)) u_time (
    .clock_in(clock_in),
    .reset_n_in(reset_n_in),
    .run_in(ctrl_reg[CTRL_RUN_BIT]),
    .pre_en_in(ctrl_reg[CTRL_PRE_BIT]),
    .prescale_in(prescale_reg),
    .period_in(period_reg),
    .restart_in(sync_pulse),
    .cnt_out(cnt),
    .step_out(step)
  );

  for (genvar m = 0; m < MATCH_NUM; m++) begin : g_hit
    assign hit[m] = cnt == match_reg[m];
  end

  // ***************************************************************
  // Channels
  // ***************************************************************
  for (genvar i = 0; i < CH_NUM; i++) begin : g_ch
    ppob_mode_e mode;
    assign mode = ppob_mode_e'(chan_reg[i][CH_MODE_LSB +: 2]);
    assign lead_v[i] = match_reg[chan_reg[i][CH_LEAD_LSB +: 2]];
    assign trail_v[i] = match_reg[chan_reg[i][CH_TRAIL_LSB +: 2]];
    // Offset zero still lands one count
    assign lead_p1[i] = lead_v[i] + 16'h0001;

    // Match use: lead only in pulse-position mode
    always_comb begin
      use_bits[i] = 8'h00;
      use_bits[i][USE_TRAILING_COMPARE_FILTER_LSB + 32'(chan_reg[i][CH_TRAIL_LSB +: 2])] = 1'b1;
      if (mode == pulse_position_mode) begin
        use_bits[i][USE_LEADING_COMPARE_FILTER_LSB + 32'(chan_reg[i][CH_LEAD_LSB +: 2])] = 1'b1;
      end
    end

    // Pulse-position state: set one count after lead, cleared at trail only.
    // No clear at period start, so a late lead wraps over
    always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
        ppm_reg[i] <= 1'b0;
      end else if (cnt == trail_v[i]) begin
        ppm_reg[i] <= 1'b0;
      end else if (cnt == lead_p1[i]) begin
        ppm_reg[i] <= 1'b1;
      end
    end

    // Counter mode toggles on the trail compare alone
    always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
        tog_reg[i] <= 1'b0;
      end else if (step && cnt == trail_v[i]) begin
        tog_reg[i] <= !tog_reg[i];
      end
    end

    // Unsigned less-than gives 0 never high, period always high
    always_comb begin
      case (mode)
        pulse_position_mode: active[i] = ppm_reg[i];
        mode_counter: active[i] = tog_reg[i];
        default: active[i] = cnt < trail_v[i];
      endcase
    end

    // Disabled: park level; enabled: live level, maybe inverted
    always_ff @(posedge clock_in) begin
      if (!reset_n_in) begin
        pin_reg[i] <= 1'b0;
      end else if (!chan_reg[i][CH_EN_BIT]) begin
        pin_reg[i] <= chan_reg[i][CH_PARK_BIT];
      end else begin
        pin_reg[i] <= active[i] ^ chan_reg[i][CH_INV_BIT];
      end
    end
  end

  assign pulse_output_pins_out = pin_reg;

  // ***************************************************************
  // Checks
  // ***************************************************************
  default clocking top_cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  sequence wb_req_s;
    wb_cyc_in && wb_stb_in && !wb_ack_out;
  endsequence
  sequence wb_ack_s;
    wb_ack_out ##1 !wb_ack_out;
  endsequence
  chk_bus_ack_timing: assert property (wb_req_s |=> wb_ack_s)
    else $error("bus ack not given for exactly one cycle");

  chk_bound_trail: assert property (wb_wr && is_match && wb_sel_in == 4'hf &&
    chan_reg[0][CH_TRAIL_LSB +: 2] == sub_idx[1:0]
    |=> trail_v[0] == $past(wb_dat_in[CNT_W-1:0]))
    else $error("bound channel missed duty change");
  chk_park_level: assert property (!chan_reg[0][CH_EN_BIT] |=>
    pulse_output_pins_out[0] == $past(chan_reg[0][CH_PARK_BIT]))
    else $error("disabled channel not at park level");
  chk_pwm_duty: assert property (chan_reg[1][CH_EN_BIT] &&
    g_ch[1].mode == mode_pwm |=> pulse_output_pins_out[1] ==
    (($past(cnt) < $past(trail_v[1])) ^ $past(chan_reg[1][CH_INV_BIT])))
    else $error("pulse width level wrong");
  sequence ppm_lead_s;
    g_ch[2].mode == pulse_position_mode && chan_reg[2][CH_EN_BIT] &&
    cnt == lead_p1[2] && cnt != trail_v[2];
  endsequence
  chk_ppm_lead_edge: assert property (ppm_lead_s ##1 $stable(chan_reg[2]) |=>
    pulse_output_pins_out[2] == !$past(chan_reg[2][CH_INV_BIT], 2))
    else $error("leading edge not one count past offset");
  chk_ppm_trail_edge: assert property (g_ch[2].mode == pulse_position_mode &&
    chan_reg[2][CH_EN_BIT] && cnt == trail_v[2] ##1 $stable(chan_reg[2])
    |=> pulse_output_pins_out[2] == $past(chan_reg[2][CH_INV_BIT]))
    else $error("trailing edge not honoured");
  chk_counter_no_lead: assert property (g_ch[3].mode == mode_counter |->
    use_bits[3][USE_LEADING_COMPARE_FILTER_LSB +: 4] == 4'h0)
    else $error("counter channel reports lead use");
  chk_block_sync: assert property (sync_pulse && ctrl_reg[CTRL_RUN_BIT]
    |=> cnt == '0 && step)
    else $error("block not resynchronised");

endmodule

/* hdl/ppob_pkg.sv */
// Package of the pulse-width / pulse-position output block.
// Holds register offsets, field positions, reset values and timing counts.
// Assumes a 100 MHz clock and a 32-bit classic Wishbone register bus.
package ppob_pkg;

  // ***************************************************************
  // Sizes
  // ***************************************************************
  localparam int CH_NUM = 8;        // Output channels per block
  localparam int MATCH_NUM = 4;     // Match registers per block
  localparam int CNT_W = 16;        // Counter and compare width
  localparam int EXT_SYNC_NUM = 4;  // Input-capable pins usable as sync
  localparam int SRC_W = 3;         // Sync source select width

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam longint CLK_HZ = 100_000_000;
  localparam longint FREQ_MAX_HZ = 50_000;
  localparam longint FREQ_MIN_HZ = 2;
  // Shortest period in clocks, fastest rate rounded down
  localparam int PERIOD_MIN = int'(CLK_HZ / FREQ_MAX_HZ);

  // ***************************************************************
  // Register offsets (byte addresses)
  // ***************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_PRESCALE = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [2:0] PAGE_MATCH = 3'h1;  // 0x10..0x1c, adr[7:5]=0
  localparam logic [2:0] PAGE_CHAN = 3'h1;   // 0x20..0x3c, adr[7:5]
  localparam logic [2:0] PAGE_USE = 3'h2;    // 0x40..0x5c, adr[7:5]

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int CTRL_EDGE_LSB = 0;  // Two bits, sync edge select
  localparam int CTRL_SRC_LSB = 2;   // Three bits, 0 global, k ext pin k-1
  localparam int CTRL_PRE_BIT = 5;   // Counter runs on prescaled clock
  localparam int CTRL_RUN_BIT = 6;   // Period counter runs
  localparam int CTRL_W = 7;
  localparam int CH_LEAD_LSB = 0;    // Two bits, lead match select
  localparam int CH_TRAIL_LSB = 2;   // Two bits, trail match select
  localparam int CH_MODE_LSB = 4;    // Two bits, channel mode
  localparam int CH_INV_BIT = 6;     // Output inverted
  localparam int CH_EN_BIT = 7;      // Pulse generation enabled
  localparam int CH_PARK_BIT = 8;    // Level held while disabled
  localparam int CH_W = 9;
  localparam int USE_LEADING_COMPARE_FILTER_LSB = 0;
  localparam int USE_TRAILING_COMPARE_FILTER_LSB = 4;
  localparam int COMPARE_HIT_ZERO = 0;
  localparam int COMPARE_HIT_ONE = 1;
  localparam int COMPARE_HIT_TWO = 2;
  localparam int COMPARE_HIT_THREE = 3;
  localparam int STAT_HIT_LSB = 8;   // Live compare hits in status

  // ***************************************************************
  // Reset values
  // ***************************************************************
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam logic [CNT_W-1:0] PERIOD_RST = 16'h07d0;
  localparam logic [CNT_W-1:0] PRESCALE_RST = 16'h0000;
  localparam logic [CNT_W-1:0] MATCH_RST = 16'h0000;
  localparam logic [CH_W-1:0] CH_RST = 9'h000;

  // ***************************************************************
  // Encodings
  // ***************************************************************
  typedef enum logic [1:0] {
    sync_off, sync_on_rising, sync_on_falling, sync_on_either
  } ppob_edge_e;
  typedef enum logic [1:0] {
    mode_pwm, pulse_position_mode, mode_counter, mode_spare
  } ppob_mode_e;

endpackage

/* hdl/ppob_timebase.sv */
// Period counter of one block, on the main or the prescaled clock.
// Assumes restart_in is a one-cycle pulse from the sync edge detector.
`timescale 1ns/1ns
module ppob_timebase #(
  parameter int CNT_W = ppob_pkg::CNT_W
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic run_in,
  input wire logic pre_en_in,
  input wire logic [CNT_W-1:0] prescale_in,
  input wire logic [CNT_W-1:0] period_in,
  input wire logic restart_in,
  output logic [CNT_W-1:0] cnt_out,
  output logic step_out
);
  import ppob_pkg::*;

  logic [CNT_W-1:0] pre_reg;   // Prescale divider
  logic [CNT_W-1:0] last_cnt;  // Final count of the period
  logic tick;                  // Counter advances this cycle

  // Floor on the unprescaled period keeps the rate usable
  assign last_cnt = (!pre_en_in && period_in < CNT_W'(PERIOD_MIN)) ?
                    CNT_W'(PERIOD_MIN - 1) : period_in - 1'b1;
  assign tick = !pre_en_in || pre_reg == prescale_in;

  // ***************************************************************
  // Prescaler
  // ***************************************************************
  always_ff @(posedge clock_in) begin
    if (!reset_n_in || restart_in || !run_in || tick) begin
      pre_reg <= '0;
    end else begin
      pre_reg <= pre_reg + 1'b1;
    end
  end

  // ***************************************************************
  // Period counter, restarted at period end or on sync
  // ***************************************************************
  always_ff @(posedge clock_in) begin
    if (!reset_n_in) begin
      cnt_out <= '0;
      step_out <= 1'b0;
    end else begin
      step_out <= restart_in || (run_in && tick);
      if (restart_in || !run_in) begin
        cnt_out <= '0;  // Sync lands within one count
      end else if (tick) begin
        // Wrap on >= so a shortened period never runs to all ones
        cnt_out <= (cnt_out >= last_cnt) ? '0 : cnt_out + 1'b1;
      end
    end
  end

  default clocking tb_cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  chk_sync_restart: assert property (restart_in |=> cnt_out == '0)
    else $error("counter did not restart on sync");
  chk_period_floor: assert property (run_in && !pre_en_in && !restart_in &&
    cnt_out >= CNT_W'(PERIOD_MIN - 1) && period_in <= CNT_W'(PERIOD_MIN)
    |=> cnt_out == '0)
    else $error("period shorter than the fastest usable rate");

endmodule

/* hdl/ppob_sync_detect.sv */
// Sync source select and edge detector of one block.
// Assumes sync inputs are synchronous to clock_in.
`timescale 1ns/1ns
module ppob_sync_detect #(
  parameter int EXT_NUM = ppob_pkg::EXT_SYNC_NUM
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic global_sync_in,
  input wire logic [EXT_NUM-1:0] ext_sync_in,
  input wire logic [ppob_pkg::SRC_W-1:0] src_in,
  input wire ppob_pkg::ppob_edge_e edge_in,
  output logic sync_out,
  output logic [EXT_NUM-1:0] claim_out
);
  import ppob_pkg::*;

  logic lvl;       // Level of the chosen source
  logic prev_reg;  // Level one cycle ago

  // Source 0 is the chip-wide sync, k selects pin k-1
  always_comb begin
    lvl = global_sync_in;
    if (src_in != '0 && int'(src_in) <= EXT_NUM) begin
      lvl = ext_sync_in[int'(src_in) - 1];
    end
  end

  // Tracks the source in reset too, so a line idling high gives no
  // false edge on the first cycle after release
  always_ff @(posedge clock_in) begin
    prev_reg <= lvl;
  end

  // Edge filter; sync_off gives no pulse at all
  always_comb begin
    case (edge_in)
      sync_on_rising: sync_out = lvl && !prev_reg;
      sync_on_falling: sync_out = !lvl && prev_reg;
      sync_on_either: sync_out = lvl != prev_reg;
      default: sync_out = 1'b0;
    endcase
  end

  // A pin is taken only while sync is on; else it is a plain input
  for (genvar k = 0; k < EXT_NUM; k++) begin : g_claim
    assign claim_out[k] = edge_in != sync_off && int'(src_in) == k + 1;
  end

  default clocking sd_cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  chk_sync_off_quiet: assert property (edge_in == sync_off |->
    !sync_out && claim_out == '0)
    else $error("sync active while edge select is off");
  chk_falling_edge: assert property (edge_in == sync_on_falling &&
    $fell(lvl) && $stable(src_in) |-> sync_out)
    else $error("falling sync edge missed");

endmodule

/* verification/ppob_sync_model.sv */
// Model of the far side: the global and external sync sources.
// Assumes the bench calls set_line between transfers; lines are synchronous.
`timescale 1ns/1ns
module ppob_sync_model (
  input wire logic clock_in,
  output logic global_out,
  output logic [3:0] ext_out
);
  // All sync lines idle low until the bench moves one
  initial begin
    global_out = 1'b0;
    ext_out = 4'h0;
  end
  // Index 4 is the global line; the rest are pins 0-3
  // A level moves only on a rising edge, never between edges
  task automatic set_line(input int idx, input logic lvl);
    @(posedge clock_in);
    if (idx == 4) begin
      global_out <= lvl;
    end else begin
      ext_out[idx] <= lvl;
    end
  endtask
endmodule

/* verification/tb_top.sv */
// Self-checking bench of the pulse output block, driven over Wishbone.
// Assumes the sync model moves the sync lines on rising clock edges.
`timescale 1ns/1ns
module tb_top;
  import ppob_pkg::*;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic wb_cyc_in = 1'b0;
  logic wb_stb_in = 1'b0;
  logic wb_we_in = 1'b0;
  logic [7:0] wb_adr_in = 8'h00;
  logic [31:0] wb_dat_in = 32'h0;
  logic [3:0] wb_sel_in = 4'hf;
  logic [31:0] wb_dat_out, rd;
  logic wb_ack_out, gsync;
  logic [3:0] esync, claim;
  logic [7:0] pins;
  int fail_count = 0;
  int samples_checked = 0;
  always #5 clock_in = ~clock_in;
  ppob_top dut (.clock_in(clock_in), .reset_n_in(reset_n_in), .wb_cyc_in(wb_cyc_in),
    .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in), .wb_dat_in(wb_dat_in),
    .wb_sel_in(wb_sel_in), .wb_dat_out(wb_dat_out), .wb_ack_out(wb_ack_out),
    .global_sync_in(gsync), .ext_sync_in(esync), .ext_sync_claim_out(claim),
    .pulse_output_pins_out(pins));
  ppob_sync_model partner (.clock_in(clock_in), .global_out(gsync), .ext_out(esync));
  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One classic cycle, held until ack is sampled high; bounded wait
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
    int n;
    @(posedge clock_in);
    wb_cyc_in <= 1'b1;
    wb_stb_in <= 1'b1;
    wb_we_in <= we;
    wb_sel_in <= 4'hf;
    wb_adr_in <= adr;
    wb_dat_in <= dat;
    n = 0;
    do begin
      @(posedge clock_in);
      n++;
    end while (wb_ack_out !== 1'b1 && n < 20);
    rd = wb_dat_out;
    wb_cyc_in <= 1'b0;
    wb_stb_in <= 1'b0;
    if (n >= 20 && wb_ack_out !== 1'b1) begin
      fail_count++;
      report_and_stop();
    end
  endtask
  task automatic rchk(input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 32'h0);
    check(rd, exp);
  endtask
  // High cycles over two periods of 10 counts, after settling
  task automatic duty(input int ch, input int exp);
    int hi;
    hi = 0;
    repeat (30) @(posedge clock_in);
    repeat (20) begin
      @(posedge clock_in);
      hi += int'(pins[ch] === 1'b1);
    end
    check(32'(hi), 32'(exp));
  endtask
  // Wait for pin 0 low mid-period, move a sync line, see if it restarts
  task automatic sync_try(input logic [6:0] c, input int idx, input logic lv, input logic ex);
    int n;
    wb(1'b1, ADDR_CTRL, 32'(c));
    check(32'(claim), (c[1:0] != 0 && c[4:2] inside {[1:4]}) ? 1 << (c[4:2] - 1) : 0);
    n = 0;
    // Catch the high-to-low edge so the counter sits near the trail value
    while (pins[0] !== 1'b1 && n < 300) begin
      @(posedge clock_in);
      n++;
    end
    while (pins[0] !== 1'b0 && n < 300) begin
      @(posedge clock_in);
      n++;
    end
    if (n >= 300) begin
      fail_count++;
      report_and_stop();
    end
    repeat (5) @(posedge clock_in);
    partner.set_line(idx, lv);
    repeat (5) @(posedge clock_in);
    check(32'(pins[0]), 32'(ex));
  endtask
  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial begin
    repeat (6) @(posedge clock_in);
    reset_n_in <= 1'b1;
    rchk(ADDR_PERIOD, 32'(PERIOD_RST));
    wb(1'b1, 8'h80, 32'hffff_ffff);
    rchk(8'h80, 32'h0);
    wb(1'b1, ADDR_PERIOD, 32'd10);
    wb(1'b1, ADDR_CTRL, 32'h60);
    wb(1'b1, 8'h10, 32'd7);
    wb(1'b1, 8'h14, 32'd2);
    wb(1'b1, 8'h20, 32'h80);
    wb(1'b1, 8'h24, 32'h80);
    wb(1'b1, 8'h28, 32'h91);
    duty(0, 14);
    duty(2, 8);
    wb(1'b1, 8'h10, 32'd5);
    duty(1, 10);
    duty(2, 4);
    wb(1'b1, 8'h14, 32'd0);
    duty(2, 8);
    wb(1'b1, 8'h14, 32'd7);
    duty(2, 14);
    wb(1'b1, 8'h28, 32'hd1);
    duty(2, 6);
    wb(1'b1, 8'h24, 32'h100);
    duty(1, 20);
    wb(1'b1, 8'h24, 32'h000);
    duty(1, 0);
    wb(1'b1, 8'h24, 32'h80);
    duty(1, 10);
    wb(1'b1, 8'h10, 32'd0);
    duty(0, 0);
    wb(1'b1, 8'h10, 32'd10);
    duty(0, 20);
    rchk(8'h48, 32'h12);
    wb(1'b1, 8'h2c, 32'h29);
    rchk(8'h4c, 32'h40);
    wb(1'b1, 8'h2c, 32'ha9);
    duty(3, 10);
    wb(1'b1, ADDR_PERIOD, 32'd100);
    wb(1'b1, 8'h10, 32'd50);
    sync_try(7'h65, 0, 1'b1, 1'b1);
    sync_try(7'h66, 0, 1'b0, 1'b1);
    sync_try(7'h66, 0, 1'b1, 1'b0);
    sync_try(7'h67, 0, 1'b0, 1'b1);
    sync_try(7'h71, 3, 1'b1, 1'b1);
    sync_try(7'h61, 4, 1'b1, 1'b1);
    sync_try(7'h64, 0, 1'b1, 1'b0);
    report_and_stop();
  end
endmodule
